// file: hw/paired_timer_pkg.sv
// Constants and register map for the paired 32-bit timer block
package paired_timer_pkg;
   localparam int unsigned NUM_TIMERS = 4;
   localparam logic [11:0] CTRL_BASE = 12'h000;
   localparam logic [11:0] COUNT_BASE = 12'h010;
   localparam logic [11:0] PERIOD_BASE = 12'h020;
   localparam logic [11:0] FLAG_OFS = 12'h030;
   localparam logic [11:0] SEL_OFS = 12'h034;
   localparam int unsigned CTRL_ON = 15;
   localparam int unsigned CTRL_SIDL = 13;
   localparam int unsigned CTRL_GATE = 6;
   localparam int unsigned CTRL_PS_HI = 5;
   localparam int unsigned CTRL_PS_LO = 4;
   localparam int unsigned CTRL_T32 = 3;
   localparam int unsigned CTRL_TCS = 1;
   localparam logic [15:0] CTRL_MASK = 16'hA07A;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [6:0] SEL_RESET = 7'h00;
   localparam logic [6:0] SEL_TIED_LOW = 7'h00;
   localparam int unsigned SEL_INPUTS = 128;
   localparam logic [7:0] PS_DIV1 = 8'h00;
   localparam logic [7:0] PS_DIV8 = 8'h07;
   localparam logic [7:0] PS_DIV64 = 8'h3F;
   localparam logic [7:0] PS_DIV256 = 8'hFF;
endpackage

// file: hw/timer_word.sv
// One 16-bit timer word with prescaler, gate and external clock
`timescale 1ns/1ps
`default_nettype none
module timer_word
   import paired_timer_pkg::*;
#(
   parameter int unsigned WIDTH = 16
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic run,
   input wire logic ext_mode,
   input wire logic ext_rise,
   input wire logic gate_mode,
   input wire logic gate_level,
   input wire logic [1:0] prescale,
   input wire logic carry_in,
   input wire logic chained,
   input wire logic clear,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   output logic [WIDTH-1:0] count,
   output logic tick,
   output logic rollover
);
   logic [7:0] pre_r;
   logic [7:0] pre_nxt;
   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;
   logic [7:0] limit;
   logic edge_in;

   always_comb
   begin
      unique case (prescale)
         2'd0: limit = PS_DIV1;
         2'd1: limit = PS_DIV8;
         2'd2: limit = PS_DIV64;
         2'd3: limit = PS_DIV256;
      endcase
      edge_in = run && (ext_mode ? ext_rise : (gate_mode ? gate_level : 1'b1));
      tick = 1'b0;
      pre_nxt = pre_r;
      if (!chained && edge_in)
      begin
         if (pre_r >= limit)
         begin
            pre_nxt = 8'h00;
            tick = 1'b1;
         end
         else
         begin
            pre_nxt = pre_r + 8'h01;
         end
      end
      if (chained)
      begin
         tick = carry_in;
      end
      rollover = tick && (count_r == {WIDTH{1'b1}});
      count_nxt = count_r;
      if (load)
      begin
         count_nxt = load_value;
      end
      else if (clear)
      begin
         count_nxt = '0;
      end
      else if (tick)
      begin
         count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pre_r <= 8'h00;
         count_r <= '0;
      end
      else
      begin
         pre_r <= pre_nxt;
         count_r <= count_nxt;
      end
   end

   assign count = count_r;
endmodule
`default_nettype wire

// file: hw/paired_timer_32bit.sv
// Top of the two timer pairs with APB register access
`timescale 1ns/1ps
`default_nettype none
module paired_timer_32bit
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [paired_timer_pkg::SEL_INPUTS-1:0] remappable_inputs,
   input wire logic [paired_timer_pkg::NUM_TIMERS-1:0] ext_clock_pins,
   input wire logic [paired_timer_pkg::NUM_TIMERS-1:0] gate_pins,
   input wire logic idle_mode,
   output logic [paired_timer_pkg::NUM_TIMERS-1:0] period_flags,
   output logic converter_trigger,
   output logic [paired_timer_pkg::NUM_TIMERS-1:0] dma_request,
   output logic [31:0] capture_time_base
);
   import paired_timer_pkg::*;

   logic [15:0] ctrl_r [NUM_TIMERS];
   logic [15:0] ctrl_nxt [NUM_TIMERS];
   logic [15:0] period_r [NUM_TIMERS];
   logic [15:0] period_nxt [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] flag_r;
   logic [NUM_TIMERS-1:0] flag_nxt;
   logic [6:0] sel_r;
   logic [6:0] sel_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pready_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic trig_r;
   logic trig_nxt;
   logic [NUM_TIMERS-1:0] dma_r;
   logic [NUM_TIMERS-1:0] dma_nxt;
   logic [31:0] base_r;
   logic [31:0] base_nxt;
   logic [NUM_TIMERS-1:0] ext_sync1_r;
   logic [NUM_TIMERS-1:0] ext_sync2_r;
   logic [NUM_TIMERS-1:0] ext_prev_r;
   logic [NUM_TIMERS-1:0] ext_rise;
   logic [NUM_TIMERS-1:0] clk_src;
   logic [NUM_TIMERS-1:0] load;
   logic [NUM_TIMERS-1:0] clear;
   logic [NUM_TIMERS-1:0] run;
   logic [NUM_TIMERS-1:0] match;
   logic [NUM_TIMERS-1:0] tick;
   logic [NUM_TIMERS-1:0] roll;
   logic [NUM_TIMERS-1:0] ctrl_sel;
   logic [NUM_TIMERS-1:0] cnt_sel;
   logic [NUM_TIMERS-1:0] per_sel;
   logic [15:0] count [NUM_TIMERS];
   logic [1:0] pair_join;
   logic wr;
   logic rd;
   logic access;

   assign access = psel && penable && !pready_r;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;

   always_comb
   begin
      clk_src = ext_clock_pins;
      clk_src[0] = (sel_r == SEL_TIED_LOW) ? 1'b0 : remappable_inputs[sel_r];
   end

   // Edge detect reads the second stage and its delayed copy ext_prev_r
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ext_sync1_r <= '0;
         ext_sync2_r <= '0;
         ext_prev_r <= '0;
      end
      else
      begin
         ext_sync1_r <= clk_src;
         ext_sync2_r <= ext_sync1_r;
         ext_prev_r <= ext_sync2_r;
      end
   end
   assign ext_rise = ext_sync2_r & ~ext_prev_r;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIMERS; gi++)
      begin : g_tmr
         localparam int unsigned LO = gi & 2;
         localparam bit HI = (gi % 2) == 1;
         logic joined;
         logic [15:0] c;
         assign joined = pair_join[gi/2];
         assign c = joined ? ctrl_r[LO] : ctrl_r[gi];
         assign run[gi] = c[CTRL_ON] && !(c[CTRL_SIDL] && idle_mode);
         assign cnt_sel[gi] = wr && (paddr == COUNT_BASE + 12'(4 * gi));
         assign load[gi] = cnt_sel[gi];
         assign clear[gi] = joined ? match[LO + 1] : match[gi];
         timer_word #(.WIDTH(16)) u_word (
            .clk(clk),
            .reset(reset),
            .run(run[gi]),
            .ext_mode(c[CTRL_TCS]),
            .ext_rise(ext_rise[LO + (joined ? 0 : gi % 2)]),
            .gate_mode(c[CTRL_GATE] && !c[CTRL_TCS]),
            .gate_level(gate_pins[LO + (joined ? 0 : gi % 2)]),
            .prescale(c[CTRL_PS_HI:CTRL_PS_LO]),
            .carry_in(HI ? roll[LO] : 1'b0),
            .chained(HI && joined),
            .clear(clear[gi]),
            .load(load[gi]),
            .load_value(pwdata[15:0]),
            .count(count[gi]),
            .tick(tick[gi]),
            .rollover(roll[gi])
         );
      end
   endgenerate

   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         pair_join[p] = ctrl_r[2*p][CTRL_T32];
         if (pair_join[p])
         begin
            match[2*p] = 1'b0;
            match[2*p+1] = tick[2*p] && ({count[2*p+1], count[2*p]}
               == {period_r[2*p+1], period_r[2*p]});
         end
         else
         begin
            match[2*p] = tick[2*p] && (count[2*p] == period_r[2*p]);
            match[2*p+1] = tick[2*p+1] && (count[2*p+1] == period_r[2*p+1]);
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
         ctrl_sel[i] = (paddr == CTRL_BASE + 12'(4 * i));
         per_sel[i] = (paddr == PERIOD_BASE + 12'(4 * i));
         ctrl_nxt[i] = ctrl_r[i];
         period_nxt[i] = period_r[i];
         if (wr && ctrl_sel[i])
         begin
            ctrl_nxt[i] = pwdata[15:0] & CTRL_MASK;
         end
         if (wr && per_sel[i])
         begin
            period_nxt[i] = pwdata[15:0];
         end
      end
      flag_nxt = flag_r;
      if (wr && paddr == FLAG_OFS)
      begin
         flag_nxt = flag_r & ~pwdata[NUM_TIMERS-1:0];
      end
      flag_nxt = flag_nxt | match;
      sel_nxt = sel_r;
      if (wr && paddr == SEL_OFS)
      begin
         sel_nxt = pwdata[6:0];
      end
      pready_nxt = access;
      pslverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (rd)
      begin
         for (int i = 0; i < NUM_TIMERS; i++)
         begin
            if (ctrl_sel[i])
            begin
               prdata_nxt = {16'h0000, ctrl_r[i]};
            end
            if (cnt_sel[i] || paddr == COUNT_BASE + 12'(4 * i))
            begin
               prdata_nxt = {16'h0000, count[i]};
            end
            if (per_sel[i])
            begin
               prdata_nxt = {16'h0000, period_r[i]};
            end
         end
         if (paddr == FLAG_OFS)
         begin
            prdata_nxt = {28'h000_0000, flag_r};
         end
         if (paddr == SEL_OFS)
         begin
            prdata_nxt = {25'h000_0000, sel_r};
         end
      end
      if (access && !(paddr >= CTRL_BASE && paddr <= SEL_OFS && paddr[1:0] == 2'b00))
      begin
         pslverr_nxt = 1'b1;
      end
      trig_nxt = match[1] || match[3];
      dma_nxt = match;
      base_nxt = pair_join[0] ? {count[1], count[0]} : {count[1], count[0]};
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < NUM_TIMERS; i++)
         begin
            ctrl_r[i] <= CTRL_RESET;
            period_r[i] <= PERIOD_RESET;
         end
         flag_r <= '0;
         sel_r <= SEL_RESET;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         trig_r <= 1'b0;
         dma_r <= '0;
         base_r <= 32'h0000_0000;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         period_r <= period_nxt;
         flag_r <= flag_nxt;
         sel_r <= sel_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         trig_r <= trig_nxt;
         dma_r <= dma_nxt;
         base_r <= base_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign period_flags = flag_r;
   assign converter_trigger = trig_r;
   assign dma_request = dma_r;
   assign capture_time_base = base_r;

   a_joined_flag_high: assert property (@(posedge clk) disable iff (reset)
      pair_join[0] && match[1] |=> flag_r[1]) else $error("joined match lost");
   a_joined_low_quiet: assert property (@(posedge clk) disable iff (reset)
      pair_join[0] |-> !match[0]) else $error("low word matched");
   a_trig_source: assert property (@(posedge clk) disable iff (reset)
      converter_trigger |-> $past(match[1] || match[3])) else $error("bad trigger");
   // Every match must land in its flag, even when software clears it in the same cycle
   a_flag_set_wins: assert property (@(posedge clk) disable iff (reset)
      match != '0 |=> (flag_r & $past(match)) == $past(match)) else $error("flag set lost");
   a_carry_high: assert property (@(posedge clk) disable iff (reset)
      pair_join[0] && roll[0] && !match[1] && !load[1]
      |=> count[1] == $past(count[1]) + 16'h0001) else $error("no carry");
   a_match_clears: assert property (@(posedge clk) disable iff (reset)
      pair_join[0] && match[1] && !load[0] && !load[1]
      |=> count[0] == 16'h0000 && count[1] == 16'h0000) else $error("no clear");
   a_sel_width: assert property (@(posedge clk) disable iff (reset)
      wr && paddr == SEL_OFS |=> sel_r == $past(pwdata[6:0])) else $error("select lost");
   a_pready_pulse: assert property (@(posedge clk) disable iff (reset)
      pready |=> !pready) else $error("pready stuck");
   a_off_stands: assert property (@(posedge clk) disable iff (reset)
      !run[0] && !load[0] && !clear[0] |=> $stable(count[0])) else $error("drift");
endmodule
`default_nettype wire

// file: tb/edge_source.sv
// Model of an external clock source feeding a remappable input
`timescale 1ns/1ps
`default_nettype none
module edge_source
(
   input wire logic clk,
   input wire logic reset,
   input wire logic go,
   input wire logic [7:0] pulses,
   output logic line
);
   logic [8:0] halves_r;
   logic [1:0] div_r;
   // Slow edges, four cycles per half, so the two-flop synchroniser never misses one
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         halves_r <= 9'h000;
         div_r <= 2'h0;
         line <= 1'b0;
      end
      else if (go)
      begin
         halves_r <= {pulses, 1'b0};
         div_r <= 2'h0;
      end
      else if (halves_r != 9'h000)
      begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3)
         begin
            // Even count of halves, so the line stands low between bursts
            line <= ~line;
            halves_r <= halves_r - 9'h001;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the paired timer block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
   import paired_timer_pkg::*;
   typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic er;} row_t;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, conv, go, line, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, ctb, rd;
   logic [NUM_TIMERS-1:0] flags, dma;
   logic [SEL_INPUTS-1:0] remap;
   logic [7:0] pulses;
   int error_cnt = 0;
   int tests_run = 0;
   int n, conv_cnt, c0;
   row_t rows [12] = '{
      '{12'h000, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{12'h020, 1'b0, 32'h0000_0000, 32'h0000_FFFF, 1'b0},
      '{12'h034, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{12'h030, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{12'h034, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
      '{12'h034, 1'b0, 32'h0000_0000, 32'h0000_007F, 1'b0},
      '{12'h034, 1'b1, 32'h0000_0079, 32'h0000_0000, 1'b0},
      '{12'h034, 1'b0, 32'h0000_0000, 32'h0000_0079, 1'b0},
      '{12'h000, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
      '{12'h000, 1'b0, 32'h0000_0000, 32'h0000_A07A, 1'b0},
      '{12'h000, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{12'h038, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1}};
   assign remap = {6'h00, line, 121'h0};
   paired_timer_32bit uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .remappable_inputs(remap), .ext_clock_pins(4'h0),
      .gate_pins(4'h0), .idle_mode(1'b0), .period_flags(flags), .converter_trigger(conv),
      .dma_request(dma), .capture_time_base(ctb));
   edge_source src (.clk(clk), .reset(reset), .go(go), .pulses(pulses), .line(line));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
      if (conv === 1'b1)
         conv_cnt++;
   task automatic give_verdict;
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1 && ++k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK("pready", 1'b1, pready)
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return dma[0];
         1: return conv;
         2: return flags[1];
         default: return flags[0];
      endcase
   endfunction
   task automatic wait_ev(input int k, input int lim);
      n = 0;
      while (sig(k) !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("event", 1'b1, sig(k))
   endtask
   // Stop and zero every timer, so a later match is not hidden behind a wrap
   task automatic stop_all;
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
         apb(CTRL_BASE + 12'(4 * i), 1'b1, 32'h0000_0000);
         apb(COUNT_BASE + 12'(4 * i), 1'b1, 32'h0000_0000);
      end
      apb(FLAG_OFS, 1'b1, 32'h0000_000F);
   endtask
   task automatic burst;
      pulses <= 8'h03;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   initial
   begin
      reset = 1'b1;
      {psel, penable, pwrite, go, conv_cnt} = '0;
      {paddr, pwdata, pulses} = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      foreach (rows[i])
      begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         `CHK("pslverr", rows[i].er, er)
         if (!rows[i].w && !rows[i].er)
            `CHK("prdata", rows[i].e, rd)
      end
      apb(12'h020, 1'b1, 32'h0000_0004);
      apb(12'h000, 1'b1, 32'h0000_8000);
      c0 = conv_cnt;
      wait_ev(0, 50);
      @(posedge clk);
      `CHK("flag0", 1'b1, flags[0])
      `CHK("conv2", c0, conv_cnt)
      stop_all();
      apb(FLAG_OFS, 1'b0, 32'h0000_0000);
      `CHK("flagclr", 32'h0000_0000, rd)
      apb(12'h024, 1'b1, 32'h0000_0003);
      apb(12'h004, 1'b1, 32'h0000_8000);
      wait_ev(1, 50);
      stop_all();
      apb(12'h020, 1'b1, 32'h0000_0002);
      apb(12'h000, 1'b1, 32'h0000_8002);
      repeat (20) @(posedge clk);
      `CHK("idle0", 1'b0, flags[0])
      burst();
      wait_ev(3, 100);
      stop_all();
      apb(12'h020, 1'b1, 32'h0000_0001);
      apb(12'h024, 1'b1, 32'h0000_0000);
      apb(12'h000, 1'b1, 32'h0000_800A);
      burst();
      wait_ev(2, 100);
      `CHK("lowflag", 1'b0, flags[0])
      stop_all();
      apb(12'h020, 1'b1, 32'h0000_0002);
      apb(12'h024, 1'b1, 32'h0000_0001);
      // Join first, so the higher timer never runs alone on its short period
      apb(12'h000, 1'b1, 32'h0000_8008);
      apb(12'h004, 1'b1, 32'h0000_8000);
      wait_ev(2, 70000);
      `CHK("carry", 1'b1, n > 65530)
      `CHK("lowflag32", 1'b0, flags[0])
      // Mid-run reset drops sticky flags and restores the periods
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      `CHK("rstflag", 4'h0, flags)
      apb(PERIOD_BASE, 1'b0, 32'h0000_0000);
      `CHK("rstper", 32'h0000_FFFF, rd)
      apb(COUNT_BASE, 1'b1, 32'h0000_1234);
      apb(COUNT_BASE + 12'h004, 1'b1, 32'h0000_5678);
      @(posedge clk);
      `CHK("timebase", 32'h5678_1234, ctb)
      give_verdict();
   end
   // Internal 32-bit match needs about 65540 cycles, everything else well under 2000
   initial
   begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end
endmodule
`default_nettype wire
